/* connection_word_decode.v */
// Decoder of one low connection word into its switching controls
`timescale 1ns/10ps
`default_nettype none
`include "tdm_memmap_consts.vh"

module connection_word_decode (
  input  wire [15:0] word,
  output reg         special_mode,
  output reg  [4:0]  src_stream,
  output reg  [7:0]  src_channel,
  output reg         use_variable,
  output reg         companding_on,
  output reg         pc_tristate,
  output reg         pc_message,
  output reg         pc_ber_test
);

  reg [1:0] per_channel_control_code;

  always @* begin
    per_channel_control_code = word[`CWL_CODE_HI:`CWL_CODE_LO];
    special_mode  = word[`CWL_MODE_BIT];
    src_stream    = 5'h00;
    src_channel   = 8'h00;
    use_variable  = 1'b0;
    companding_on = word[`CWL_COMP_BIT];
    pc_tristate   = 1'b0;
    pc_message    = 1'b0;
    pc_ber_test   = 1'b0;
    if (!word[`CWL_MODE_BIT]) begin
      src_channel  = word[`CWL_SCH_HI:`CWL_SCH_LO];
      src_stream   = word[`CWL_SST_HI:`CWL_SST_LO];
      use_variable = word[`CWL_VAR_BIT];
    end else begin
      case (per_channel_control_code)
        `CHAN_TRISTATE: pc_tristate = 1'b1;
        `CHAN_MESSAGE:  pc_message  = 1'b1;
        `CHAN_BER_TEST: pc_ber_test = 1'b1;
        default:       pc_tristate = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* host_port_model.sv */
// Host processor model for the non-multiplexed port
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input wire logic        clk_sys,
  input wire logic [15:0] rdata,
  output logic            cs, wr, rd,
  output logic [13:0]     addr,
  output logic [15:0]     wdata
);
  initial begin
    {cs, wr, rd} = 3'h0;
    addr = 14'h0000;
    wdata = 16'h0000;
  end
  // Request held over one edge; on release the controls clear and address and data show the inverse
  task automatic access(input logic w, input logic [13:0] a,
                        input logic [15:0] d);
    @(posedge clk_sys);
    {cs, wr, rd} <= {1'b1, w, !w};
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    {cs, wr, rd} <= 3'h0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic write_word(input logic [13:0] a, input logic [15:0] d);
    access(1'b1, a, d);
  endtask
  task automatic read_word(input logic [13:0] a, output logic [15:0] d);
    access(1'b0, a, 16'h0000);
    @(negedge clk_sys);
    d = rdata;
  endtask
endmodule
`default_nettype wire

/* tdm_connection_memory_map.v */
// Processor-port decode of data and connection memory space of a TDM switch
// Summary of operation
// - With the top address bit high an access goes to memory, not registers.
// - Control bits 1-0 pick data memory, low or high connection word.
// - Streams at 2.048 Mbps use channels 0-31, at 4.096 Mbps channels 0-63.
// - Streams at 8.192 Mbps use channels 0-127, at 16.384 Mbps 0-255.
// - A clear mode bit in the low word means normal channel switching.
// - In normal mode bits 13-1 of the low word give source stream/channel.
// - Bits 8-1 are the source channel and bits 13-9 the source stream.
// - Bit 14 picks constant delay when clear, variable delay when set.
// - A set mode bit selects a special per-channel mode.
// - Codes 00, 01, 10 give tristate, message, bit-error test; 11 reserved.
`timescale 1ns/10ps
`default_nettype none
`include "tdm_memmap_consts.vh"

module tdm_connection_memory_map #(
  parameter STREAMS  = 32,
  parameter CHANNELS = 256
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [13:0] addr,
  input  wire [15:0] wdata,
  input  wire        cs,
  input  wire        wr,
  input  wire        rd,
  input  wire [63:0] stream_rate,
  input  wire [4:0]  out_stream,
  input  wire [7:0]  out_channel,
  output reg  [15:0] rdata,
  output reg         rdata_valid,
  output reg         chan_in_use,
  output reg         special_mode,
  output reg  [4:0]  src_stream,
  output reg  [7:0]  src_channel,
  output reg         use_variable,
  output reg         companding_on,
  output reg         pc_tristate,
  output reg         pc_message,
  output reg         pc_ber_test,
  output reg         variable_delay_enable
);

  // One word per stream and channel in each memory
  localparam DEPTH = STREAMS * CHANNELS;

  // ====================================================================
  // Storage
  // Control register and the three memories reached from memory space
  reg [15:0] ctrl_r;
  reg [15:0] data_mem   [0:DEPTH-1];
  reg [15:0] conn_low   [0:DEPTH-1];
  reg [15:0] conn_high  [0:DEPTH-1];

  // Stream in the upper bits, channel in the lower bits
  function [12:0] mem_index;
    input [4:0] st;
    input [7:0] ch;
    begin
      mem_index = {st, ch};
    end
  endfunction

  // Highest channel in use at each stream rate
  function channel_ok;
    input [1:0] rate;
    input [7:0] ch;
    begin
      case (rate)
        `RATE_2M:  channel_ok = (ch <= `CH_LAST_2M);
        `RATE_4M:  channel_ok = (ch <= `CH_LAST_4M);
        `RATE_8M:  channel_ok = (ch <= `CH_LAST_8M);
        default:   channel_ok = (ch <= `CH_LAST_16M);
      endcase
    end
  endfunction

  // ====================================================================
  // Host access decode
  wire        mem_space = addr[`MEM_SPACE_BIT];
  wire [4:0]  a_stream  = addr[`STREAM_HI:`STREAM_LO];
  wire [7:0]  a_channel = addr[`CHANNEL_HI:`CHANNEL_LO];
  wire [12:0] a_idx     = mem_index(a_stream, a_channel);
  wire [1:0]  sel       = ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO];
  wire        ctrl_hit  = !mem_space && (addr[12:0] == `CTRL_ADDR);
  wire        do_wr     = cs && wr;
  wire        do_rd     = cs && rd;
  wire        ctrl_wr   = do_wr && ctrl_hit;

  // ====================================================================
  // Control register
  // The only register of this block; other register offsets are ignored
  // on write and read as zero. The enable is not policed here: the host
  // must set it before any channel asks for variable delay.
  // Bits 1-0 pick the memory reached by the host, bit 3 is the enable
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= wdata;
    end
  end

  // The enable leaves through its own flip-flop, one clock after the write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      variable_delay_enable <= 1'b0;
    end else begin
      variable_delay_enable <= ctrl_r[`CTRL_VAR_EN_BIT];
    end
  end

  // ====================================================================
  // Memory write port
  // Memories carry no reset; they hold whatever the host last wrote.
  // Select code 3 is reserved: writes are dropped and reads give zero.
  always @(posedge clk_sys) begin
    if (do_wr && mem_space) begin
      case (sel)
        `SEL_DATA_MEM:  data_mem[a_idx]  <= wdata;
        `SEL_CONN_LOW:  conn_low[a_idx]  <= wdata;
        `SEL_CONN_HIGH: conn_high[a_idx] <= wdata;
        default:        data_mem[a_idx]  <= data_mem[a_idx];
      endcase
    end
  end

  // ====================================================================
  // Read port
  reg [15:0] rd_nxt;

  // Register space other than the control register reads as zero
  always @* begin
    rd_nxt = 16'h0000;
    if (mem_space) begin
      case (sel)
        `SEL_DATA_MEM:  rd_nxt = data_mem[a_idx];
        `SEL_CONN_LOW:  rd_nxt = conn_low[a_idx];
        `SEL_CONN_HIGH: rd_nxt = conn_high[a_idx];
        default:        rd_nxt = 16'h0000;
      endcase
    end else if (ctrl_hit) begin
      rd_nxt = ctrl_r;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata       <= 16'h0000;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= do_rd;
      // Read data holds until the next read
      if (do_rd) begin
        rdata <= rd_nxt;
      end
    end
  end

  // ====================================================================
  // Switching-side lookup of one output channel
  // Position of the output channel being looked up
  wire [12:0] o_idx  = mem_index(out_stream, out_channel);
  // Two rate bits per stream: stream n sits at bits 2n+1 and 2n
  wire [1:0]  o_rate = stream_rate[{out_stream, 1'b0} +: 2];
  wire [15:0] o_word = conn_low[o_idx];

  // Decoded fields of the low connection word
  wire        d_special;
  wire [4:0]  d_stream;
  wire [7:0]  d_channel;
  wire        d_var;
  wire        d_comp;
  wire        d_tri;
  wire        d_msg;
  wire        d_ber;

  // Decode of the low word; the high word is stored but not decoded here
  connection_word_decode u_decode (
    .word          (o_word),
    .special_mode  (d_special),
    .src_stream    (d_stream),
    .src_channel   (d_channel),
    .use_variable  (d_var),
    .companding_on (d_comp),
    .pc_tristate   (d_tri),
    .pc_message    (d_msg),
    .pc_ber_test   (d_ber)
  );

  // ====================================================================
  // Lookup registers
  // Every result is registered, so it follows out_* and the memory by
  // one clock
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_in_use           <= 1'b0;
      special_mode          <= 1'b0;
      src_stream            <= 5'h00;
      src_channel           <= 8'h00;
      use_variable          <= 1'b0;
      companding_on         <= 1'b0;
      pc_tristate           <= 1'b0;
      pc_message            <= 1'b0;
      pc_ber_test           <= 1'b0;
    end else begin
      chan_in_use           <= channel_ok(o_rate, out_channel);
      special_mode          <= d_special;
      src_stream            <= d_stream;
      src_channel           <= d_channel;
      use_variable          <= d_var;
      companding_on         <= d_comp;
      pc_tristate           <= d_tri;
      pc_message            <= d_msg;
      pc_ber_test           <= d_ber;
    end
  end

endmodule
`default_nettype wire

/* tdm_map_asserts.sv */
// Checker for the memory port and the connection word lookup
`timescale 1ns/10ps
`default_nettype none
module tdm_map_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cs,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        rdata_valid,
  input wire logic        chan_in_use,
  input wire logic        special_mode,
  input wire logic        use_variable,
  input wire logic        pc_tristate,
  input wire logic        pc_message,
  input wire logic        pc_ber_test,
  input wire logic        variable_delay_enable,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic [63:0] stream_rate,
  input wire logic [4:0]  out_stream,
  input wire logic [4:0]  src_stream,
  input wire logic [7:0]  out_channel,
  input wire logic [7:0]  src_channel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] rate;
  logic [7:0] lim;
  assign rate = stream_rate[2*out_stream +: 2];
  assign lim = {rate == 2'h3, rate[1], rate != 2'h0, 5'h1f};
  sequence rd_req; cs && rd; endsequence
  sequence ctrl_wr; cs && wr && addr == 14'h0000; endsequence
  a_read_answer: assert property (rd_req |=> rdata_valid)
    else $error("no read valid");
  a_valid_pulse: assert property (!(cs && rd) |=> !rdata_valid)
    else $error("read valid without read");
  a_reg_refused: assert property (
    cs && rd && !addr[13] && addr[12:0] != 13'h0 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!(cs && rd) |=> $stable(rdata))
    else $error("read data moved");
  a_ctrl_write: assert property (
    ctrl_wr |-> ##2 variable_delay_enable == $past(wdata[3], 2))
    else $error("enable not written");
  a_ctrl_hold: assert property (
    !(cs && wr && addr == 14'h0000) |-> ##2 $stable(variable_delay_enable))
    else $error("enable moved");
  a_chan_range: assert property (
    1'b1 |=> chan_in_use == $past(out_channel <= lim))
    else $error("channel range wrong");
  a_special_clear: assert property (special_mode |->
    src_stream == 5'h00 && src_channel == 8'h00 && !use_variable)
    else $error("source set in special mode");
  a_chan_mode_onehot: assert property (
    $onehot0({pc_tristate, pc_message, pc_ber_test}))
    else $error("several channel modes");
  a_chan_mode_bit: assert property (
    pc_tristate || pc_message || pc_ber_test |-> special_mode)
    else $error("channel mode without mode bit");
endmodule
`default_nettype wire

/* tdm_memmap_consts.vh */
// Constants for the connection memory address map and word layout
`ifndef TDM_MEMMAP_CONSTS_VH
`define TDM_MEMMAP_CONSTS_VH

// ======================================================================
// Address fields
`define MEM_SPACE_BIT      13
`define STREAM_HI          12
`define STREAM_LO          8
`define CHANNEL_HI         7
`define CHANNEL_LO         0

// ======================================================================
// Control register fields and codes
`define CTRL_ADDR          13'h0000
`define CTRL_RESET         16'h0000
`define CTRL_SEL_HI        1
`define CTRL_SEL_LO        0
`define CTRL_VAR_EN_BIT    3
`define SEL_DATA_MEM       2'h0
`define SEL_CONN_LOW       2'h1
`define SEL_CONN_HIGH      2'h2

// ======================================================================
// Low connection word fields
`define CWL_MODE_BIT       0
`define CWL_SCH_HI         8
`define CWL_SCH_LO         1
`define CWL_SST_HI         13
`define CWL_SST_LO         9
`define CWL_VAR_BIT        14
`define CWL_COMP_BIT       15
`define CWL_CODE_HI        2
`define CWL_CODE_LO        1
`define CWL_RESET          16'h0000

// ======================================================================
// Per-channel control codes
`define CHAN_TRISTATE      2'h0
`define CHAN_MESSAGE       2'h1
`define CHAN_BER_TEST      2'h2
`define CHAN_RESERVED      2'h3

// ======================================================================
// Stream rate codes
`define RATE_2M            2'h0
`define RATE_4M            2'h1
`define RATE_8M            2'h2
`define RATE_16M           2'h3
`define CH_LAST_2M         8'h1f
`define CH_LAST_4M         8'h3f
`define CH_LAST_8M         8'h7f
`define CH_LAST_16M        8'hff

`endif

/* test_tdm_connection_memory_map.sv */
// Testbench for the memory port and the connection word lookup
`timescale 1ns/10ps
`default_nettype none
module test_tdm_connection_memory_map;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cs, wr, rd, rdata_valid, chan_in_use, special_mode;
  logic        use_variable, companding_on, pc_tristate, pc_message;
  logic        pc_ber_test, variable_delay_enable;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, got;
  logic [63:0] stream_rate = 64'h0;
  logic [4:0]  out_stream = 5'h05, src_stream;
  logic [7:0]  out_channel = 8'h03, src_channel, lim;
  int          n_mismatch = 0;
  int          compares = 0;
  localparam logic [15:0] WORDS [7] = '{16'h0000, 16'hc3fe, 16'h3a54,
    16'h0001, 16'h8003, 16'h0005, 16'h0007};
  always #50 clk_sys = ~clk_sys;
  tdm_connection_memory_map uut (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .addr                  (addr),
    .wdata                 (wdata),
    .cs                    (cs),
    .wr                    (wr),
    .rd                    (rd),
    .stream_rate           (stream_rate),
    .out_stream            (out_stream),
    .out_channel           (out_channel),
    .rdata                 (rdata),
    .rdata_valid           (rdata_valid),
    .chan_in_use           (chan_in_use),
    .special_mode          (special_mode),
    .src_stream            (src_stream),
    .src_channel           (src_channel),
    .use_variable          (use_variable),
    .companding_on         (companding_on),
    .pc_tristate           (pc_tristate),
    .pc_message            (pc_message),
    .pc_ber_test           (pc_ber_test),
    .variable_delay_enable (variable_delay_enable)
  );
  host_port_model host (
    .clk_sys (clk_sys),
    .rdata   (rdata),
    .cs      (cs),
    .wr      (wr),
    .rd      (rd),
    .addr    (addr),
    .wdata   (wdata)
  );
  task automatic check(input string name, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] w);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("mode", special_mode, w[0]);
    check("stream", src_stream, w[0] ? 5'h00 : w[13:9]);
    check("channel", src_channel, w[0] ? 8'h00 : w[8:1]);
    check("variable", use_variable, !w[0] && w[14]);
    check("compand", companding_on, w[15]);
    check("tristate", pc_tristate, w[0] && w[2:1] == 2'h0);
    check("message", pc_message, w[0] && w[2:1] == 2'h1);
    check("ber", pc_ber_test, w[0] && w[2:1] == 2'h2);
  endtask
  initial begin
    #(3000 * 100);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    host.read_word(14'h0000, got);
    check("ctrl reset", got, 16'h0000);
    check("enable", variable_delay_enable, 1'b0);
    host.write_word(14'h0000, 16'h000a);
    repeat (2) @(negedge clk_sys);
    check("enable set", variable_delay_enable, 1'b1);
    host.write_word(14'h2503, 16'h0001);
    host.read_word(14'h2503, got);
    check("high word", got, 16'h0001);
    host.write_word(14'h0000, 16'h0009);
    repeat (2) @(negedge clk_sys);
    check("enable", variable_delay_enable, 1'b1);
    $display("test control done");
    foreach (WORDS[i]) begin
      host.write_word(14'h2503, WORDS[i]);
      check_word(WORDS[i]);
      host.read_word(14'h2503, got);
      check("readback", got, WORDS[i]);
    end
    host.write_word(14'h2603, 16'h0000);
    host.write_word(14'h2504, 16'h0000);
    check_word(16'h0007);
    $display("test words done");
    host.write_word(14'h0100, 16'hffff);
    host.read_word(14'h0100, got);
    check("unmapped", got, 16'h0000);
    host.write_word(14'h2000, 16'h0000);
    host.read_word(14'h0000, got);
    check("ctrl kept", got, 16'h0009);
    host.write_word(14'h0000, 16'h0008);
    host.write_word(14'h2503, 16'h5a5a);
    host.read_word(14'h2503, got);
    check("data word", got, 16'h5a5a);
    check_word(16'h0007);
    host.write_word(14'h0000, 16'h0003);
    host.write_word(14'h2503, 16'h1111);
    host.read_word(14'h2503, got);
    check("select 3", got, 16'h0000);
    check("enable off", variable_delay_enable, 1'b0);
    host.write_word(14'h0000, 16'h0009);
    host.read_word(14'h2503, got);
    check("word kept", got, 16'h0007);
    $display("test refusal done");
    for (int r = 0; r < 4; r++) begin
      lim = 8'hff >> (3 - r);
      for (int k = 0; k < 2; k++) begin
        @(posedge clk_sys);
        stream_rate <= ~(64'h3 << 10) | (64'(r) << 10);
        out_channel <= lim + 8'(k);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("in use", chan_in_use, k == 0 || lim == 8'hff);
      end
    end
    $display("test range done");
    close_out;
  end
endmodule
bind tdm_connection_memory_map tdm_map_asserts chk (
  .clk_sys               (clk_sys),
  .rst                   (rst),
  .cs                    (cs),
  .wr                    (wr),
  .rd                    (rd),
  .rdata_valid           (rdata_valid),
  .chan_in_use           (chan_in_use),
  .special_mode          (special_mode),
  .use_variable          (use_variable),
  .pc_tristate           (pc_tristate),
  .pc_message            (pc_message),
  .pc_ber_test           (pc_ber_test),
  .variable_delay_enable (variable_delay_enable),
  .addr                  (addr),
  .wdata                 (wdata),
  .rdata                 (rdata),
  .stream_rate           (stream_rate),
  .out_stream            (out_stream),
  .src_stream            (src_stream),
  .out_channel           (out_channel),
  .src_channel           (src_channel)
);
`default_nettype wire
